//--- rtl/pcgc_top.sv
// Register bank gating peripheral clocks and routing serial pins and flash events
`default_nettype none
module pcgc_top
  import pcgc_pkg::*;
(
  input  wire logic        sys_clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        clk_en_in,
  input  wire logic [31:0] reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [31:0] reg_rdata_out,
  output logic             high_speed_timer_clk_en_out,
  output logic             watchdog_clk_en_out,
  output logic             port_one_clk_en_out,
  output logic             port_two_clk_en_out,
  output logic             single_level_flash_ctrl_clk_en_out,
  output logic             single_level_flash_ctrl_bus_clk_en_out,
  output logic             multi_level_flash_ctrl_clk_en_out,
  output logic             multi_level_flash_ctrl_bus_clk_en_out,
  output logic             flash_sel_single_level_out,
  input  wire logic        port_one_blk_data_in,
  input  wire logic        port_one_blk_data_oe_in,
  input  wire logic        port_one_blk_clock_in,
  input  wire logic        port_one_blk_clock_oe_in,
  input  wire logic        port_two_blk_data_in,
  input  wire logic        port_two_blk_data_oe_in,
  input  wire logic        port_two_blk_clock_in,
  input  wire logic        port_two_blk_clock_oe_in,
  output logic             port_one_data_pin_out,
  output logic             port_one_data_pin_oe_out,
  output logic             port_one_clock_pin_out,
  output logic             port_one_clock_pin_oe_out,
  output logic             port_two_data_pin_out,
  output logic             port_two_data_pin_oe_out,
  output logic             port_two_clock_pin_out,
  output logic             port_two_clock_pin_oe_out,
  input  wire logic        single_level_flash_ctrl_int_in,
  input  wire logic        multi_level_flash_ctrl_int_in,
  input  wire logic        flash_ready_busy_pin_in,
  output logic             flash_irq_out,
  output logic             flash_dma_req_out
);

  pcgc_state_t  state_q;
  pcgc_state_t  state_d;
  pcgc_route_if rif ();

  // Zero-extends a register to a bus word so unused bits read zero
  function automatic logic [31:0] pcgc_word(input logic [7:0] val);
    pcgc_word = {24'h00_0000, val};
  endfunction : pcgc_word

  function automatic logic pcgc_hit(input logic [31:0] addr, input logic [31:0] reg_addr);
    pcgc_hit = (addr == reg_addr);
  endfunction : pcgc_hit

  assign rif.spi     = state_q.spi;
  assign rif.flash   = state_q.flash;
  assign rif.rnb     = state_q.rnb_s2;
  assign rif.sgl_int = single_level_flash_ctrl_int_in;
  assign rif.mul_int = multi_level_flash_ctrl_int_in;
  assign rif.blk_lvl = {port_two_blk_data_in, port_two_blk_clock_in,
                        port_one_blk_data_in, port_one_blk_clock_in};
  assign rif.blk_oe  = {port_two_blk_data_oe_in, port_two_blk_clock_oe_in,
                        port_one_blk_data_oe_in, port_one_blk_clock_oe_in};

  pcgc_route u_route (
    .rif (rif)
  );

  always_comb begin
    state_d = state_q;
    // Ready/busy comes from a pad, synchronised before routing
    state_d.rnb_s1 = flash_ready_busy_pin_in;
    state_d.rnb_s2 = state_q.rnb_s1;
    if (reg_wr_in) begin
      if (pcgc_hit(reg_addr_in, PCGC_TIM_ADDR)) begin
        state_d.tim = reg_wdata_in[PCGC_TIM_W-1:0];
      end
      if (pcgc_hit(reg_addr_in, PCGC_SPI_ADDR)) begin
        state_d.spi = reg_wdata_in[PCGC_SPI_W-1:0];
      end
      if (pcgc_hit(reg_addr_in, PCGC_FLASH_ADDR)) begin
        state_d.flash = reg_wdata_in[PCGC_FLASH_W-1:0];
      end
    end
    // Read data stands only in the cycle after the strobe
    state_d.rdata = 32'h0000_0000;
    if (reg_rd_in) begin
      case (reg_addr_in)
        PCGC_TIM_ADDR:   state_d.rdata = pcgc_word({6'h00, state_q.tim});
        PCGC_SPI_ADDR:   state_d.rdata = pcgc_word(state_q.spi);
        PCGC_FLASH_ADDR: state_d.rdata = pcgc_word({2'h0, state_q.flash});
        default:         state_d.rdata = 32'h0000_0000;
      endcase
    end
    // Routed outputs are registered to keep pins glitch free
    state_d.pin_lvl = rif.pin_lvl;
    state_d.pin_oe  = rif.pin_oe;
    state_d.irq     = rif.irq;
    state_d.dma     = rif.dma;
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= PCGC_STATE_RST;
    end else if (clk_en_in) begin
      state_q <= state_d;
    end
  end

  assign reg_rdata_out = state_q.rdata;
  assign high_speed_timer_clk_en_out = state_q.tim[PCGC_TIM_HST];
  assign watchdog_clk_en_out = state_q.tim[PCGC_TIM_WDT];
  assign port_one_clk_en_out = state_q.spi[PCGC_P1_GATE];
  assign port_two_clk_en_out = state_q.spi[PCGC_P2_GATE];
  assign single_level_flash_ctrl_clk_en_out     = state_q.flash[PCGC_FL_SGL_EN];
  assign single_level_flash_ctrl_bus_clk_en_out = state_q.flash[PCGC_FL_SGL_EN];
  assign multi_level_flash_ctrl_clk_en_out     = state_q.flash[PCGC_FL_MUL_EN];
  assign multi_level_flash_ctrl_bus_clk_en_out = state_q.flash[PCGC_FL_MUL_EN];
  assign flash_sel_single_level_out = state_q.flash[PCGC_FL_SEL_SGL];
  assign port_two_data_pin_out      = state_q.pin_lvl[3];
  assign port_two_clock_pin_out     = state_q.pin_lvl[2];
  assign port_one_data_pin_out      = state_q.pin_lvl[1];
  assign port_one_clock_pin_out     = state_q.pin_lvl[0];
  assign port_two_data_pin_oe_out   = state_q.pin_oe[3];
  assign port_two_clock_pin_oe_out  = state_q.pin_oe[2];
  assign port_one_data_pin_oe_out   = state_q.pin_oe[1];
  assign port_one_clock_pin_oe_out  = state_q.pin_oe[0];
  assign flash_irq_out              = state_q.irq;
  assign flash_dma_req_out          = state_q.dma;

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!reset_n_in);

  sequence s_wr(logic [31:0] a);
    clk_en_in && reg_wr_in && reg_addr_in == a;
  endsequence

  sequence s_rd(logic [31:0] a);
    clk_en_in && reg_rd_in && reg_addr_in == a;
  endsequence

  a_hst_gate_write: assert property (s_wr(PCGC_TIM_ADDR) |=>
    high_speed_timer_clk_en_out == $past(reg_wdata_in[1]))
    else $error("High-speed timer gate did not follow write");

  a_wdt_gate_write: assert property (s_wr(PCGC_TIM_ADDR) |=>
    watchdog_clk_en_out == $past(reg_wdata_in[0]))
    else $error("Watchdog gate did not follow write");

  a_port_two_static: assert property (clk_en_in && !state_q.spi[5] |=>
    port_two_data_pin_out == $past(state_q.spi[7]) && port_two_clock_pin_out == $past(state_q.spi[6])
    && port_two_data_pin_oe_out && port_two_clock_pin_oe_out)
    else $error("Port two pins not at static levels");

  a_port_two_owned: assert property (clk_en_in && state_q.spi[5] |=>
    port_two_data_pin_out == $past(port_two_blk_data_in)
    && port_two_clock_pin_oe_out == $past(port_two_blk_clock_oe_in))
    else $error("Port two pins not driven by serial block");

  a_port_two_gate: assert property (s_wr(PCGC_SPI_ADDR) |=>
    port_two_clk_en_out == $past(reg_wdata_in[4]))
    else $error("Port two clock gate did not follow write");

  a_port_one_static: assert property (clk_en_in && !state_q.spi[1] |=>
    port_one_data_pin_out == $past(state_q.spi[3]) && port_one_clock_pin_out == $past(state_q.spi[2]))
    else $error("Port one pins not at static levels");

  a_port_one_owned: assert property (clk_en_in && state_q.spi[1] |=>
    port_one_clock_pin_out == $past(port_one_blk_clock_in)
    && port_one_data_pin_oe_out == $past(port_one_blk_data_oe_in))
    else $error("Port one pins not driven by serial block");

  a_port_one_gate: assert property (s_wr(PCGC_SPI_ADDR) |=>
    port_one_clk_en_out == $past(reg_wdata_in[0]))
    else $error("Port one clock gate did not follow write");

  a_flash_irq_route: assert property (clk_en_in |=>
    flash_irq_out == ($past(state_q.flash[5]) ? $past(multi_level_flash_ctrl_int_in)
                                              : $past(single_level_flash_ctrl_int_in)))
    else $error("Flash interrupt routed from wrong controller");

  sequence s_rnb_seen;
    clk_en_in && state_q.flash[4] && state_q.rnb_s2;
  endsequence

  a_dma_on_ready_busy: assert property (s_rnb_seen |=> flash_dma_req_out)
    else $error("Ready/busy did not raise DMA request");

  a_dma_on_int: assert property (clk_en_in && state_q.flash[3] && multi_level_flash_ctrl_int_in
    |=> flash_dma_req_out)
    else $error("Controller interrupt did not raise DMA request");

  a_dma_quiet: assert property (clk_en_in && !state_q.flash[4] && !state_q.flash[3] |=>
    !flash_dma_req_out)
    else $error("DMA request raised while both sources disabled");

  a_flash_select: assert property (s_wr(PCGC_FLASH_ADDR) |=>
    flash_sel_single_level_out == $past(reg_wdata_in[2]))
    else $error("Flash controller select did not follow write");

  a_mul_gate_pair: assert property (multi_level_flash_ctrl_clk_en_out ==
    multi_level_flash_ctrl_bus_clk_en_out && multi_level_flash_ctrl_clk_en_out == state_q.flash[1])
    else $error("Multi-level core and bus clock enables differ");

  a_sgl_gate_write: assert property (s_wr(PCGC_FLASH_ADDR) |=>
    single_level_flash_ctrl_clk_en_out == $past(reg_wdata_in[0]))
    else $error("Single-level gate did not follow write");

  a_sgl_bus_stop: assert property (s_wr(PCGC_FLASH_ADDR) ##0 !reg_wdata_in[0] |=>
    !single_level_flash_ctrl_bus_clk_en_out [*1])
    else $error("Single-level bus clock still enabled");

  a_read_upper_zero: assert property (s_rd(PCGC_SPI_ADDR) |=>
    reg_rdata_out[31:8] == 24'h00_0000 && reg_rdata_out[7:0] == $past(state_q.spi))
    else $error("Serial register readback wrong");

  a_read_flash_back: assert property (s_rd(PCGC_FLASH_ADDR) |=>
    reg_rdata_out == {26'h000_0000, $past(state_q.flash)})
    else $error("Flash register readback wrong");

  a_read_one_cycle: assert property (clk_en_in && !reg_rd_in |=> reg_rdata_out == 32'h0000_0000)
    else $error("Read data held beyond its cycle");

  a_read_timer_back: assert property (s_rd(PCGC_TIM_ADDR) |=>
    reg_rdata_out == {30'h0000_0000, $past(state_q.tim)})
    else $error("Timer register readback wrong");

  sequence s_hole_wr;
    clk_en_in && reg_wr_in && reg_addr_in != PCGC_TIM_ADDR
      && reg_addr_in != PCGC_SPI_ADDR && reg_addr_in != PCGC_FLASH_ADDR;
  endsequence

  sequence s_hole_rd;
    clk_en_in && reg_rd_in && reg_addr_in != PCGC_TIM_ADDR
      && reg_addr_in != PCGC_SPI_ADDR && reg_addr_in != PCGC_FLASH_ADDR;
  endsequence

  a_hole_read_zero: assert property (s_hole_rd |=> reg_rdata_out == 32'h0000_0000)
    else $error("Unmapped read returned data");

  a_hole_write_kept: assert property (s_hole_wr |=>
    $stable(state_q.tim) && $stable(state_q.spi) && $stable(state_q.flash))
    else $error("Unmapped write changed a register");

  a_hst_gate_hold: assert property (!(reg_wr_in && reg_addr_in == PCGC_TIM_ADDR) |=>
    $stable(high_speed_timer_clk_en_out))
    else $error("High-speed timer gate changed without write");

  a_wdt_gate_hold: assert property (!(reg_wr_in && reg_addr_in == PCGC_TIM_ADDR) |=>
    $stable(watchdog_clk_en_out))
    else $error("Watchdog gate changed without write");

  a_port_one_drive: assert property (clk_en_in && !state_q.spi[1] |=>
    port_one_data_pin_oe_out && port_one_clock_pin_oe_out)
    else $error("Port one static pins not driven");

  a_port_two_rest: assert property (clk_en_in && state_q.spi[5] |=>
    port_two_clock_pin_out == $past(port_two_blk_clock_in)
    && port_two_data_pin_oe_out == $past(port_two_blk_data_oe_in))
    else $error("Port two pins not fully driven by serial block");

  a_port_one_rest: assert property (clk_en_in && state_q.spi[1] |=>
    port_one_data_pin_out == $past(port_one_blk_data_in)
    && port_one_clock_pin_oe_out == $past(port_one_blk_clock_oe_in))
    else $error("Port one pins not fully driven by serial block");

  a_mul_gate_write: assert property (s_wr(PCGC_FLASH_ADDR) |=>
    multi_level_flash_ctrl_clk_en_out == $past(reg_wdata_in[1]))
    else $error("Multi-level gate did not follow write");

  a_mul_bus_stop: assert property (s_wr(PCGC_FLASH_ADDR) ##0 !reg_wdata_in[1] |=>
    !multi_level_flash_ctrl_bus_clk_en_out)
    else $error("Multi-level bus clock still enabled");

  a_sgl_gate_pair: assert property (single_level_flash_ctrl_clk_en_out ==
    single_level_flash_ctrl_bus_clk_en_out && single_level_flash_ctrl_clk_en_out == state_q.flash[0])
    else $error("Single-level core and bus clock enables differ");

  // Pin high through both sync stages and the output register
  sequence s_rnb_held;
    clk_en_in && flash_ready_busy_pin_in && state_q.flash[4]
    ##1 clk_en_in && flash_ready_busy_pin_in && state_q.flash[4]
    ##1 clk_en_in && state_q.flash[4];
  endsequence

  a_dma_after_sync: assert property (s_rnb_held |=> flash_dma_req_out)
    else $error("Ready/busy pin never reached the DMA request");

  a_dma_rnb_quiet: assert property (clk_en_in && state_q.flash[4] && !state_q.flash[3]
    && !state_q.rnb_s2 |=> !flash_dma_req_out)
    else $error("DMA request without ready/busy");

  a_dma_int_quiet: assert property (clk_en_in && state_q.flash[3] && !state_q.flash[4]
    && !multi_level_flash_ctrl_int_in |=> !flash_dma_req_out)
    else $error("DMA request without controller interrupt");

  a_irq_single_path: assert property (clk_en_in && !state_q.flash[5] |=>
    flash_irq_out == $past(single_level_flash_ctrl_int_in))
    else $error("Single-level interrupt not routed");

  a_select_hold: assert property (!(reg_wr_in && reg_addr_in == PCGC_FLASH_ADDR) |=>
    $stable(flash_sel_single_level_out))
    else $error("Flash select changed without write");

endmodule : pcgc_top
`default_nettype wire

//--- rtl/pcgc_pkg.sv
// Register map, field positions and state type for the peripheral clock gating block
`default_nettype none
package pcgc_pkg;
  localparam logic [31:0] PCGC_TIM_ADDR   = 32'h400040bc;
  localparam logic [31:0] PCGC_SPI_ADDR   = 32'h400040c4;
  localparam logic [31:0] PCGC_FLASH_ADDR = 32'h400040c8;
  localparam int PCGC_TIM_W   = 2;
  localparam int PCGC_SPI_W   = 8;
  localparam int PCGC_FLASH_W = 6;
  localparam int PCGC_TIM_HST = 1;
  localparam int PCGC_TIM_WDT = 0;
  localparam int PCGC_P2_DAT  = 7;
  localparam int PCGC_P2_CLK  = 6;
  localparam int PCGC_P2_OWN  = 5;
  localparam int PCGC_P2_GATE = 4;
  localparam int PCGC_P1_DAT  = 3;
  localparam int PCGC_P1_CLK  = 2;
  localparam int PCGC_P1_OWN  = 1;
  localparam int PCGC_P1_GATE = 0;
  localparam int PCGC_FL_IRQ_MUL = 5;
  localparam int PCGC_FL_DMA_RNB = 4;
  localparam int PCGC_FL_DMA_INT = 3;
  localparam int PCGC_FL_SEL_SGL = 2;
  localparam int PCGC_FL_MUL_EN  = 1;
  localparam int PCGC_FL_SGL_EN  = 0;
  localparam logic [PCGC_TIM_W-1:0]   PCGC_TIM_RST   = 2'h0;
  localparam logic [PCGC_SPI_W-1:0]   PCGC_SPI_RST   = 8'h00;
  localparam logic [PCGC_FLASH_W-1:0] PCGC_FLASH_RST = 6'h03;

  typedef struct packed {
    logic [PCGC_TIM_W-1:0]   tim;
    logic [PCGC_SPI_W-1:0]   spi;
    logic [PCGC_FLASH_W-1:0] flash;
    logic                    rnb_s1;
    logic                    rnb_s2;
    logic [31:0]             rdata;
    logic [3:0]              pin_lvl;
    logic [3:0]              pin_oe;
    logic                    irq;
    logic                    dma;
  } pcgc_state_t;

  localparam pcgc_state_t PCGC_STATE_RST = '{
    tim: PCGC_TIM_RST, spi: PCGC_SPI_RST, flash: PCGC_FLASH_RST,
    rnb_s1: 1'b0, rnb_s2: 1'b0, rdata: 32'h0000_0000,
    pin_lvl: 4'h0, pin_oe: 4'hf, irq: 1'b0, dma: 1'b0};
endpackage : pcgc_pkg
`default_nettype wire

//--- rtl/pcgc_route_if.sv
// Configuration and routed results between the register bank and the routing logic
`default_nettype none
interface pcgc_route_if;
  import pcgc_pkg::*;
  logic [PCGC_SPI_W-1:0]   spi;
  logic [PCGC_FLASH_W-1:0] flash;
  logic                    rnb;
  logic                    sgl_int;
  logic                    mul_int;
  // Serial block drive, order: p2 data, p2 clock, p1 data, p1 clock
  logic [3:0]              blk_lvl;
  logic [3:0]              blk_oe;
  logic [3:0]              pin_lvl;
  logic [3:0]              pin_oe;
  logic                    irq;
  logic                    dma;
  modport ctrl  (output spi, flash, rnb, sgl_int, mul_int, blk_lvl, blk_oe,
                 input pin_lvl, pin_oe, irq, dma);
  modport route (input spi, flash, rnb, sgl_int, mul_int, blk_lvl, blk_oe,
                 output pin_lvl, pin_oe, irq, dma);
endinterface : pcgc_route_if
`default_nettype wire

//--- rtl/pcgc_route.sv
// Pin ownership, interrupt and DMA request routing
`default_nettype none
module pcgc_route
  import pcgc_pkg::*;
(
  pcgc_route_if.route rif
);
  always_comb begin
    rif.pin_lvl[3] = rif.spi[PCGC_P2_OWN] ? rif.blk_lvl[3] : rif.spi[PCGC_P2_DAT];
    rif.pin_lvl[2] = rif.spi[PCGC_P2_OWN] ? rif.blk_lvl[2] : rif.spi[PCGC_P2_CLK];
    rif.pin_oe[3]  = rif.spi[PCGC_P2_OWN] ? rif.blk_oe[3]  : 1'b1;
    rif.pin_oe[2]  = rif.spi[PCGC_P2_OWN] ? rif.blk_oe[2]  : 1'b1;
    rif.pin_lvl[1] = rif.spi[PCGC_P1_OWN] ? rif.blk_lvl[1] : rif.spi[PCGC_P1_DAT];
    rif.pin_lvl[0] = rif.spi[PCGC_P1_OWN] ? rif.blk_lvl[0] : rif.spi[PCGC_P1_CLK];
    rif.pin_oe[1]  = rif.spi[PCGC_P1_OWN] ? rif.blk_oe[1]  : 1'b1;
    rif.pin_oe[0]  = rif.spi[PCGC_P1_OWN] ? rif.blk_oe[0]  : 1'b1;
    rif.irq = rif.flash[PCGC_FL_IRQ_MUL] ? rif.mul_int : rif.sgl_int;
    rif.dma = (rif.flash[PCGC_FL_DMA_RNB] & rif.rnb) | (rif.flash[PCGC_FL_DMA_INT] & rif.mul_int);
  end
endmodule : pcgc_route
`default_nettype wire

//--- testbench/pcgc_top_bench.sv
// Self-checking bench for the peripheral clock gating register block
`default_nettype none
module pcgc_top_bench
  import pcgc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              sys_clk;
  logic              reset_n;
  logic              clk_en;
  logic [31:0]       addr;
  logic [31:0]       wdata;
  logic              wr_s;
  logic              rd_s;
  logic [7:0]        blk;
  logic              sgl_int;
  logic              mul_int;
  logic              rnb;
  wire logic [31:0]  rdata;
  wire logic [7:0]   pin;
  wire logic [7:0]   en;
  wire logic         sel_sgl;
  wire logic         irq;
  wire logic         dma;
  int                bad_count = 0;
  int                cmp_count = 0;
  int                cyc = 0;
  logic [31:0]       sh [3];
  logic [31:0]       v;
  int                idx;
  // Order: timer, serial, flash
  logic [31:0]       adr [3] = '{PCGC_TIM_ADDR, PCGC_SPI_ADDR, PCGC_FLASH_ADDR};
  logic [31:0]       msk [3] = '{32'h0000_0003, 32'h0000_00ff, 32'h0000_003f};

  pcgc_top i_pcgc_top (
    .sys_clk_in                             (sys_clk),
    .reset_n_in                             (reset_n),
    .clk_en_in                              (clk_en),
    .reg_addr_in                            (addr),
    .reg_wdata_in                           (wdata),
    .reg_wr_in                              (wr_s),
    .reg_rd_in                              (rd_s),
    .reg_rdata_out                          (rdata),
    .high_speed_timer_clk_en_out            (en[0]),
    .watchdog_clk_en_out                    (en[1]),
    .port_one_clk_en_out                    (en[2]),
    .port_two_clk_en_out                    (en[3]),
    .single_level_flash_ctrl_clk_en_out     (en[4]),
    .single_level_flash_ctrl_bus_clk_en_out (en[5]),
    .multi_level_flash_ctrl_clk_en_out      (en[6]),
    .multi_level_flash_ctrl_bus_clk_en_out  (en[7]),
    .flash_sel_single_level_out             (sel_sgl),
    .port_two_blk_data_in                   (blk[7]),
    .port_two_blk_data_oe_in                (blk[6]),
    .port_two_blk_clock_in                  (blk[5]),
    .port_two_blk_clock_oe_in               (blk[4]),
    .port_one_blk_data_in                   (blk[3]),
    .port_one_blk_data_oe_in                (blk[2]),
    .port_one_blk_clock_in                  (blk[1]),
    .port_one_blk_clock_oe_in               (blk[0]),
    .port_two_data_pin_out                  (pin[7]),
    .port_two_data_pin_oe_out               (pin[6]),
    .port_two_clock_pin_out                 (pin[5]),
    .port_two_clock_pin_oe_out              (pin[4]),
    .port_one_data_pin_out                  (pin[3]),
    .port_one_data_pin_oe_out               (pin[2]),
    .port_one_clock_pin_out                 (pin[1]),
    .port_one_clock_pin_oe_out              (pin[0]),
    .single_level_flash_ctrl_int_in         (sgl_int),
    .multi_level_flash_ctrl_int_in          (mul_int),
    .flash_ready_busy_pin_in                (rnb),
    .flash_irq_out                          (irq),
    .flash_dma_req_out                      (dma)
  );

  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  // Generous ceiling; the sequence needs about 1000 cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Static mode always drives, so oe is forced high there
  function automatic logic [7:0] exp_pins(input logic [31:0] s, input logic [7:0] b);
    logic [7:0] e;
    e[7:4] = s[5] ? b[7:4] : {s[7], 1'h1, s[6], 1'h1};
    e[3:0] = s[1] ? b[3:0] : {s[3], 1'h1, s[2], 1'h1};
    return e;
  endfunction : exp_pins

  function automatic logic [7:0] exp_en();
    return {sh[2][1], sh[2][1], sh[2][0], sh[2][0], sh[1][4], sh[1][0], sh[0][0], sh[0][1]};
  endfunction : exp_en

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'h1;
    @(posedge sys_clk);
    wr_s <= 1'h0;
  endtask : wr

  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd_s <= 1'h1;
    @(posedge sys_clk);
    rd_s <= 1'h0;
    #1;
    d = rdata;
  endtask : rd

  task automatic wr_reg(input int i, input logic [31:0] d);
    wr(adr[i], d);
    sh[i] = d & msk[i];
  endtask : wr_reg

  task automatic check_regs();
    for (int i = 0; i < 3; i++) begin
      rd(adr[i], v);
      chk("reg_readback", v, sh[i]);
    end
  endtask : check_regs

  // Three edges cover the ready/busy synchroniser plus output register
  task automatic stir_and_check();
    @(posedge sys_clk);
    blk <= 8'($urandom);
    sgl_int <= 1'($urandom);
    mul_int <= 1'($urandom);
    rnb <= 1'($urandom);
    repeat (3) @(posedge sys_clk);
    #1;
    chk("clk_enables", {24'h0, en}, {24'h0, exp_en()});
    chk("flash_select", {31'h0, sel_sgl}, {31'h0, sh[2][2]});
    chk("pins", {24'h0, pin}, {24'h0, exp_pins(sh[1], blk)});
    chk("flash_irq", {31'h0, irq}, {31'h0, sh[2][5] ? mul_int : sgl_int});
    chk("flash_dma", {31'h0, dma}, {31'h0, (sh[2][4] & rnb) | (sh[2][3] & mul_int)});
  endtask : stir_and_check

  initial begin
    reset_n = 1'h0;
    clk_en = 1'h1;
    addr = 32'h0;
    wdata = 32'h0;
    wr_s = 1'h0;
    rd_s = 1'h0;
    blk = 8'h0;
    sgl_int = 1'h0;
    mul_int = 1'h0;
    rnb = 1'h0;
    sh[0] = 32'h0;
    sh[1] = 32'h0;
    sh[2] = 32'h3;
    v = $urandom(5);
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'h1;
    #1;
    chk("reset_enables", {24'h0, en}, {24'h0, exp_en()});
    chk("reset_pins", {24'h0, pin}, 32'h0000_0055);
    check_regs();
    // Undefined bits and the unmapped hole between registers
    for (int i = 0; i < 3; i++) begin
      wr_reg(i, 32'hffff_ffff);
    end
    wr(PCGC_TIM_ADDR + 32'h4, 32'hffff_ffff);
    rd(PCGC_TIM_ADDR + 32'h4, v);
    chk("unmapped_read", v, 32'h0);
    @(posedge sys_clk);
    #1;
    chk("rdata_idle", rdata, 32'h0);
    check_regs();
    stir_and_check();
    // Back to back: flash gates off, ownership back to static levels
    wr_reg(2, 32'h0000_0000);
    wr_reg(1, 32'hffff_ff48);
    stir_and_check();
    check_regs();
    // Strobe lost while the clock enable is low
    @(posedge sys_clk);
    clk_en <= 1'h0;
    wr(PCGC_SPI_ADDR, 32'h0000_00b7);
    @(posedge sys_clk);
    clk_en <= 1'h1;
    check_regs();
    for (int n = 0; n < 80; n++) begin
      idx = $urandom_range(2, 0);
      wr_reg(idx, $urandom);
      stir_and_check();
      check_regs();
    end
    report_and_stop();
  end
endmodule : pcgc_top_bench
`default_nettype wire
